// File: inc/oep_consts.svh
`ifndef OEP_CONSTS_SVH
`define OEP_CONSTS_SVH

`define OEP_OFS_PERIODIC_CURRENT 8'h1C
`define OEP_OFS_CONTROL_HEAD     8'h20
`define OEP_ADDR_MSB             31
`define OEP_ADDR_LSB             4
`define OEP_PTR_RESET            28'h0000000
`define OEP_RSVD_VALUE           4'h0

`endif

// File: inc/oep_pkg.sv
package oep_pkg;
  typedef logic [27:0] oep_addr_t;
  typedef enum logic [1:0] {
    OEP_IDLE,
    OEP_PERIODIC,
    OEP_CONTROL
  } oep_walk_t;
  typedef struct packed {
    oep_addr_t periodic_descriptor_address;
    oep_addr_t control_head_address;
    logic [31:0] rdata;
    logic        rvalid;
    oep_walk_t   walk;
    oep_addr_t   control_walk_address;
    logic        control_walk_valid;
  } oep_state_t;
endpackage

// File: rtl/oep_list_ptrs.sv
`timescale 1ns/1ps
`include "oep_consts.svh"

// Operation
// - periodic current pointer at offset 1C, bits 31..4
// - periodic pointer marks current frame list head
// - update periodic pointer after each periodic descriptor, except when frame start falls in the same cycle
// - control head pointer at offset 20, bits 31..4
// - control list walk starts at head pointer
// - control head loaded from shared area at init
module oep_list_ptrs
  import oep_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire logic             reg_rd,
  input  wire logic [7:0]       reg_addr,
  output oep_pkg::oep_addr_t    reg_rdata_unused_hi,
  output logic [31:0]           reg_rdata,
  output logic                  reg_rvalid,
  input  wire logic             frame_start,
  input  wire oep_pkg::oep_addr_t periodic_list_head,
  input  wire logic             periodic_ed_done,
  input  wire oep_pkg::oep_addr_t periodic_next_address,
  input  wire logic             init_load,
  input  wire oep_pkg::oep_addr_t shared_area_control_head,
  input  wire logic             control_walk_start,
  output oep_pkg::oep_addr_t    control_walk_address,
  output logic                  control_walk_valid,
  output oep_pkg::oep_walk_t    walk_state
);
  import oep_pkg::*;

  oep_state_t st_ff;
  oep_state_t nxt_st;

  function automatic logic [31:0] pack_ptr(input oep_addr_t a);
    pack_ptr = {a, `OEP_RSVD_VALUE};
  endfunction

  always_comb
  begin
    nxt_st        = st_ff;
    nxt_st.rvalid = 1'b0;
    nxt_st.control_walk_valid = 1'b0;
    // frame start wins over a descriptor completion in the same cycle
    if (frame_start)
    begin
      nxt_st.periodic_descriptor_address = periodic_list_head;
      nxt_st.walk = OEP_PERIODIC;
    end
    else if (periodic_ed_done)
    begin
      nxt_st.periodic_descriptor_address = periodic_next_address;
    end
    if (init_load)
    begin
      nxt_st.control_head_address = shared_area_control_head;
    end
    if (control_walk_start)
    begin
      nxt_st.control_walk_address = st_ff.control_head_address;
      nxt_st.control_walk_valid   = 1'b1;
      nxt_st.walk = OEP_CONTROL;
    end
    if (reg_rd)
    begin
      nxt_st.rvalid = 1'b1;
      // writes have no port: both registers are read only
      case (reg_addr)
        `OEP_OFS_PERIODIC_CURRENT: nxt_st.rdata = pack_ptr(st_ff.periodic_descriptor_address);
        `OEP_OFS_CONTROL_HEAD:     nxt_st.rdata = pack_ptr(st_ff.control_head_address);
        default:                   nxt_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff.periodic_descriptor_address <= `OEP_PTR_RESET;
      st_ff.control_head_address        <= `OEP_PTR_RESET;
      st_ff.rdata                       <= 32'h00000000;
      st_ff.rvalid                      <= 1'b0;
      st_ff.walk                        <= OEP_IDLE;
      st_ff.control_walk_address        <= `OEP_PTR_RESET;
      st_ff.control_walk_valid          <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata_unused_hi  = st_ff.control_head_address;
  assign reg_rdata            = st_ff.rdata;
  assign reg_rvalid           = st_ff.rvalid;
  assign control_walk_address = st_ff.control_walk_address;
  assign control_walk_valid   = st_ff.control_walk_valid;
  assign walk_state           = st_ff.walk;
endmodule

// File: tb/oep_list_ptrs_properties.sv
`timescale 1ns/1ps
module oep_props
  import oep_pkg::*;
(
  input wire logic clk_sys, reset_n, reg_rd, reg_rvalid, init_load, control_walk_start, control_walk_valid,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire oep_pkg::oep_addr_t shared_area_control_head, control_walk_address
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("no answer");
  rv_pulse_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray valid");
  low_zero_a: assert property (reg_rvalid |-> reg_rdata[3:0] == 4'h0) else $error("low bits");
  unmapped_zero_a: assert property (reg_rd && reg_addr != 8'h1C && reg_addr != 8'h20 |=> !reg_rdata)
    else $error("unmapped");
  head_load_a: assert property (init_load ##1 reg_rd && reg_addr == 8'h20 |=>
    reg_rdata[31:4] == $past(shared_area_control_head, 2)) else $error("head");
  walk_head_a: assert property (init_load ##1 control_walk_start |=>
    control_walk_address == $past(shared_area_control_head, 2)) else $error("walk");
  walk_pulse_a: assert property (control_walk_start |=> control_walk_valid) else $error("no walk");
  reset_zero_a: assert property ($rose(reset_n) |-> !reg_rdata) else $error("reset");
  cover property (init_load ##1 control_walk_start);
  cover property (init_load ##1 reg_rd && reg_addr == 8'h20);
  cover property (reg_rd && reg_addr == 8'h1C);
endmodule
bind oep_list_ptrs oep_props i_props (.*);

// File: tb/oep_list_ptrs_tb.sv
`timescale 1ns/1ps
module oep_list_ptrs_tb;
  import oep_pkg::*;
  logic clk_sys = 0, reset_n = 0, reg_rd = 0, frame_start = 0, periodic_ed_done = 0, init_load = 0;
  logic control_walk_start = 0, reg_rvalid, control_walk_valid, ev = 0, go = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_rdata, ed = 0, r;
  oep_addr_t periodic_list_head = 0, periodic_next_address = 0, shared_area_control_head = 0;
  oep_addr_t reg_rdata_unused_hi, control_walk_address, pm = 0, cm = 0, cw = 0;
  logic [1:0] ws = 0;
  logic cwv = 0;
  oep_walk_t walk_state;
  int num_errors = 0, n_compared = 0;
  oep_list_ptrs i_dut (.*);
  always #12.5 clk_sys = ~clk_sys;
  task chk(logic [31:0] g, logic [31:0] e);
    n_compared++;
    num_errors += int'(g !== e);
    if (g !== e) $display("FAIL %0t got %h", $time, g);
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // model: a read returns the pointer as it stood before same-edge updates
  always @(posedge clk_sys)
  if (go)
  begin
    ev <= reg_rd;
    if (reg_rd) ed <= reg_addr == 8'h1C ? {pm, 4'h0} : reg_addr == 8'h20 ? {cm, 4'h0} : 32'h0;
    if (frame_start) pm <= periodic_list_head;
    else if (periodic_ed_done) pm <= periodic_next_address;
    if (init_load) cm <= shared_area_control_head;
    cwv <= control_walk_start;
    if (control_walk_start) cw <= cm;
    if (frame_start) ws <= 2'h1;
    if (control_walk_start) ws <= 2'h2;
    r = $urandom;
    {reg_rd, frame_start, periodic_ed_done, init_load, control_walk_start} <= r[4:0];
    reg_addr <= r[5] ? r[15:8] : (r[6] ? 8'h20 : 8'h1C);
    {periodic_list_head, periodic_next_address, shared_area_control_head} <= {r[31:4], ~r[31:4], r[27:0]};
  end
  always @(negedge clk_sys)
  if (reset_n)
  begin
    chk(reg_rvalid, ev);
    chk(reg_rdata, ed);
    chk(control_walk_valid, cwv);
    chk(control_walk_address, cw);
    chk(walk_state, ws);
    chk(reg_rdata_unused_hi, cm);
  end
  initial
  begin
    void'($urandom(32'hE07B));
    repeat (12) @(posedge clk_sys);
    reset_n <= 1;
    go <= 1;
    repeat (3000) @(posedge clk_sys);
    $display("random traffic test done");
    final_report;
  end
  initial
  begin
    #100000;
    num_errors++;
    final_report;
  end
endmodule
